/* File: verilog/hub_ctrl_cfg.svh */
/*
 * register offsets, field positions, reset values and codes for the hub
 * port and endpoint control block; assumes includers use the macros only
 */
`ifndef HUB_CTRL_CFG_SVH
`define HUB_CTRL_CFG_SVH
`define OFF_UP_STAT_CTRL 8'h1F
`define OFF_PORT_SUSPEND 8'h4D
`define OFF_RESUME_STAT 8'h4E
`define OFF_SE0_STAT 8'h4F
`define OFF_PORT_ENABLE 8'h49
`define OFF_DIFF_DATA 8'h50
`define OFF_EP_MODE 8'h12
`define OFF_HUB_IRQ_EN 8'h60
`define BIT_BUS_ACT 3
`define BIT_DM_UP 4
`define BIT_DP_UP 5
`define BIT_REMOTE_WAKE 7
`define BIT_EP_STALL 7
`define RST_REG8 8'h00
`define MODE_DISABLE 4'h0
`define MODE_NAK_INOUT 4'h1
`endif

/* File: verilog/hub_ctrl_pkg.sv */
/*
 * types shared by the hub port and endpoint control block; assumes the
 * configuration header supplies all numbers
 */
package hub_ctrl_pkg;
   // upstream line drive request
   typedef struct packed {
      logic dp_out; // d+ level
      logic dp_oe; // d+ driven
      logic dm_out; // d- level
      logic dm_oe; // d- driven
   } up_drive_t;
   // handshake answer of the endpoint
   typedef enum logic [2:0] {
      ANS_NONE, ANS_ACK, ANS_NAK, ANS_STALL, ANS_TX, ANS_TX0, ANS_CHECK
   } ep_answer_t;
   // token kind decoded by the engine
   typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} token_t;
endpackage

/* File: verilog/hub_ctrl.sv */
/*
 * hub repeater port control and upstream engine control with apb registers.
 * assumes the repeater datapath and packet engine sit outside and report
 * line states, frame points and token events as one-cycle pulses.
 */
// Behaviour
// - port enable waits for packet end
// - suspended hub interrupts on connect change
// - enable register bits 0..3, reset clears
// - babble clears port enable bit
// - babble: traffic or no eop at frame end
// - se0 status per port, read only
// - differential data per port, read only
// - suspended port gets no traffic, foreign resume
// - port resume reflected, flagged, interrupt raised
// - disconnect clears selective suspend bit
// - remote wake bit gates connect resume upstream
// - remote wakeup always resumes upstream
// - suspend and resume status clear on reset
// - upstream status control clears on async reset, not on bus reset
// - control action code drives upstream pins
// - bus activity sticky, write zero clears
// - upstream pin levels read at bits 4,5
// - eop generated at first frame end point
// - low endpoint modes answer per table
// - high modes, stall bit, ack transitions
// - setup forces mode nak in out
// - setup acked, endpoint resets disabled
`include "hub_ctrl_cfg.svh"
module hub_ctrl (
   input wire logic i_sys_clk, // 125 mhz clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_bus_reset, // usb bus reset level
   input wire logic [7:0] i_paddr, // apb address
   input wire logic i_psel, // apb select
   input wire logic i_penable, // apb access phase
   input wire logic i_pwrite, // apb write
   input wire logic [31:0] i_pwdata, // apb write data
   output logic [31:0] o_prdata, // apb read data
   output logic o_pready, // apb ready
   output logic o_pslverr, // apb error
   input wire logic i_pkt_active, // packet in transmission
   input wire logic i_hub_suspended, // global suspend
   input wire logic [3:0] i_conn_change, // connect/disconnect pulse
   input wire logic [3:0] i_disconnect, // disconnect pulse
   input wire logic [3:0] i_ds_nonidle, // downstream non idle
   input wire logic i_up_conn_open, // upstream path open, no eop
   input wire logic [3:0] i_ds_resume, // resume seen on port
   input wire logic i_remote_wake, // downstream wakeup pulse
   input wire logic [3:0] i_ds_se0_out, // se0 driven on port
   input wire logic [3:0] i_ds_dp, // port d+ level
   input wire logic [3:0] i_ds_dm, // port d- level
   input wire logic i_frame_end1, // first frame end point
   input wire logic i_frame_end2, // second frame end point
   input wire logic i_up_nonidle, // upstream non idle event
   input wire logic i_up_dp, // upstream d+ level
   input wire logic i_up_dm, // upstream d- level
   input wire logic i_tok_valid, // token pulse
   input wire hub_ctrl_pkg::token_t i_tok, // token kind
   input wire logic i_ack_done, // ack issued pulse
   output logic [3:0] o_port_fwd, // forward traffic to port
   output logic [3:0] o_port_resume_drive, // reflect resume onto port
   output logic o_up_resume, // resume upstream request
   output logic o_hub_irq, // hub interrupt pulse
   output logic o_eop_gen, // generate eop pulse
   output logic o_manual_force, // upstream under firmware
   output hub_ctrl_pkg::up_drive_t o_up_drive, // forced upstream drive
   output hub_ctrl_pkg::ep_answer_t o_ep_answer // endpoint handshake
);
   logic [7:0] enable_ff; // port enables
   logic [3:0] pend_en_ff; // enables waiting for packet end
   logic [7:0] suspend_ff; // suspend register
   logic [3:0] resume_ff; // resume status
   logic [7:0] usc_ff; // upstream status control writable bits
   logic irq_en_ff; // hub interrupt enable
   logic [7:0] ep_mode_ff; // endpoint mode, stall at bit 7
   logic [3:0] babble; // babble detected per port
   logic [3:0] res_evt; // resume from suspended port
   logic wr_en; // write commit
   logic [7:0] wdat; // write byte
   logic [7:0] nxt_rdata; // read mux
   logic [3:0] mode; // current mode nibble
   logic stall_bit; // endpoint stall
   logic any_rst; // bus reset pending
   logic [3:0] nxt_mode; // next endpoint mode

   // apb answers in the access phase with no wait
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign wdat = i_pwdata[7:0];
   assign any_rst = i_bus_reset;
   assign mode = ep_mode_ff[3:0];
   assign stall_bit = ep_mode_ff[`BIT_EP_STALL];

   // babble at second frame point on enabled ports
   assign babble = i_frame_end2 ? (enable_ff[3:0] &
      (i_ds_nonidle | {4{i_up_conn_open}})) : 4'h0;
   // resume coming from a suspended port itself
   assign res_evt = i_ds_resume & suspend_ff[3:0];

   // port enable register with deferred enable
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enable_ff <= `RST_REG8;
         pend_en_ff <= 4'h0;
      end else if (any_rst) begin
         enable_ff <= `RST_REG8;
         pend_en_ff <= 4'h0;
      end else begin
         if (wr_en && i_paddr == `OFF_PORT_ENABLE) begin
            // disables act at once, enables wait while busy
            enable_ff[3:0] <= enable_ff[3:0] & wdat[3:0] &
               ~babble;
            pend_en_ff <= wdat[3:0] & ~enable_ff[3:0];
         end else begin
            if (!i_pkt_active) begin
               // traffic idle: pending enables land
               enable_ff[3:0] <= (enable_ff[3:0] | pend_en_ff) &
                  ~babble;
               pend_en_ff <= 4'h0;
            end else begin
               enable_ff[3:0] <= enable_ff[3:0] & ~babble;
               pend_en_ff <= pend_en_ff & ~babble;
            end
         end
         enable_ff[7:4] <= 4'h0; // reserved
      end
   end

   // selective suspend register and remote wake control
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         suspend_ff <= `RST_REG8;
      end else if (any_rst) begin
         suspend_ff <= `RST_REG8;
      end else if (wr_en && i_paddr == `OFF_PORT_SUSPEND) begin
         // hardware clear wins over a simultaneous set
         suspend_ff <= {wdat[7], 3'h0, wdat[3:0] & ~i_disconnect};
      end else begin
         suspend_ff[3:0] <= suspend_ff[3:0] & ~i_disconnect;
      end
   end

   // resume status, sticky, write zero clears, set wins
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         resume_ff <= 4'h0;
      end else if (any_rst) begin
         resume_ff <= 4'h0;
      end else if (wr_en && i_paddr == `OFF_RESUME_STAT) begin
         resume_ff <= (resume_ff & wdat[3:0]) | res_evt;
      end else begin
         resume_ff <= resume_ff | res_evt;
      end
   end

   // upstream status control and interrupt enable
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         usc_ff <= `RST_REG8;
         irq_en_ff <= 1'b0;
      end else begin
         if (wr_en && i_paddr == `OFF_UP_STAT_CTRL) begin
            usc_ff[2:0] <= wdat[2:0];
            usc_ff[7:6] <= wdat[7:6];
            // write 0 clears, write 1 keeps, event wins
            usc_ff[`BIT_BUS_ACT] <= (usc_ff[`BIT_BUS_ACT] &
               wdat[`BIT_BUS_ACT]) | i_up_nonidle;
         end else begin
            usc_ff[`BIT_BUS_ACT] <= usc_ff[`BIT_BUS_ACT] |
               i_up_nonidle;
         end
         usc_ff[5:4] <= 2'h0; // live bits not stored
         if (wr_en && i_paddr == `OFF_HUB_IRQ_EN) begin
            irq_en_ff <= wdat[0];
         end
      end
   end

   // endpoint mode with hardware transitions
   always_comb begin
      nxt_mode = mode;
      if (i_tok_valid && i_tok == hub_ctrl_pkg::TOK_SETUP &&
          mode != `MODE_DISABLE && o_ep_answer == hub_ctrl_pkg::ANS_ACK) begin
         nxt_mode = `MODE_NAK_INOUT;
      end else if (i_ack_done) begin
         case (mode)
            4'h9: nxt_mode = 4'h8;
            4'hB: nxt_mode = 4'hA;
            4'hD: nxt_mode = 4'hC;
            4'hF: nxt_mode = 4'hE;
            default: nxt_mode = mode;
         endcase
      end
   end

   // endpoint mode register, firmware write then hardware
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ep_mode_ff <= {4'h0, `MODE_DISABLE};
      end else if (any_rst) begin
         ep_mode_ff <= {4'h0, `MODE_DISABLE};
      end else if (wr_en && i_paddr == `OFF_EP_MODE) begin
         ep_mode_ff <= wdat;
      end else begin
         ep_mode_ff[3:0] <= nxt_mode;
      end
   end

   // handshake answer from mode and token
   always_comb begin
      o_ep_answer = hub_ctrl_pkg::ANS_NONE;
      if (i_tok == hub_ctrl_pkg::TOK_SETUP) begin
         case (mode)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB, 4'hE, 4'hF:
               o_ep_answer = hub_ctrl_pkg::ANS_ACK;
            default: o_ep_answer = hub_ctrl_pkg::ANS_NONE;
         endcase
      end else if (i_tok == hub_ctrl_pkg::TOK_IN) begin
         case (mode)
            4'h1, 4'hC, 4'hE: o_ep_answer = hub_ctrl_pkg::ANS_NAK;
            4'h2, 4'h3: o_ep_answer = hub_ctrl_pkg::ANS_STALL;
            4'h6, 4'hA, 4'hB: o_ep_answer = hub_ctrl_pkg::ANS_TX0;
            4'h7, 4'hF: o_ep_answer = hub_ctrl_pkg::ANS_TX;
            4'hD: o_ep_answer = stall_bit ? hub_ctrl_pkg::ANS_STALL :
               hub_ctrl_pkg::ANS_TX;
            default: o_ep_answer = hub_ctrl_pkg::ANS_NONE;
         endcase
      end else begin
         case (mode)
            4'h1, 4'h8, 4'hA: o_ep_answer = hub_ctrl_pkg::ANS_NAK;
            4'h3, 4'h6: o_ep_answer = hub_ctrl_pkg::ANS_STALL;
            4'h2, 4'hE, 4'hF: o_ep_answer = hub_ctrl_pkg::ANS_CHECK;
            4'h5, 4'hB: o_ep_answer = hub_ctrl_pkg::ANS_ACK;
            4'h9: o_ep_answer = stall_bit ? hub_ctrl_pkg::ANS_STALL :
               hub_ctrl_pkg::ANS_ACK;
            default: o_ep_answer = hub_ctrl_pkg::ANS_NONE;
         endcase
      end
   end

   // upstream manual drive decode
   always_comb begin
      o_up_drive = '{dp_out: 1'b0, dp_oe: 1'b1, dm_out: 1'b0, dm_oe: 1'b1};
      case (usc_ff[2:0])
         3'h1: o_up_drive.dp_out = 1'b1;
         3'h2: o_up_drive.dm_out = 1'b1;
         3'h5: o_up_drive.dp_oe = 1'b0;
         3'h6: o_up_drive.dm_oe = 1'b0;
         3'h7: begin
            o_up_drive.dp_oe = 1'b0;
            o_up_drive.dm_oe = 1'b0;
         end
         3'h0: begin
            o_up_drive.dp_oe = 1'b0; // engine owns the driver
            o_up_drive.dm_oe = 1'b0;
         end
         default: o_up_drive.dp_out = 1'b0; // 011 and 100 drive low
      endcase
   end
   assign o_manual_force = usc_ff[2:0] != 3'h0;

   // repeater steering, events and interrupt
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_fwd <= 4'h0;
         o_port_resume_drive <= 4'h0;
         o_up_resume <= 1'b0;
         o_hub_irq <= 1'b0;
         o_eop_gen <= 1'b0;
      end else begin
         o_port_fwd <= enable_ff[3:0] & ~suspend_ff[3:0];
         o_port_resume_drive <= res_evt;
         o_up_resume <= i_remote_wake |
            (suspend_ff[`BIT_REMOTE_WAKE] & (|i_conn_change));
         o_hub_irq <= irq_en_ff & ((|res_evt) |
            (|(babble & enable_ff[3:0])) |
            (|(i_conn_change & (enable_ff[3:0] |
               {4{i_hub_suspended}}))));
         o_eop_gen <= i_frame_end1;
      end
   end

   // apb read mux
   always_comb begin
      case (i_paddr)
         `OFF_UP_STAT_CTRL: nxt_rdata = {usc_ff[7:6], i_up_dp, i_up_dm,
            usc_ff[3:0]};
         `OFF_PORT_SUSPEND: nxt_rdata = suspend_ff;
         `OFF_RESUME_STAT: nxt_rdata = {4'h0, resume_ff};
         `OFF_SE0_STAT: nxt_rdata = {4'h0, i_ds_se0_out};
         `OFF_PORT_ENABLE: nxt_rdata = enable_ff;
         `OFF_DIFF_DATA: nxt_rdata = {4'h0, i_ds_dp & ~i_ds_dm};
         `OFF_EP_MODE: nxt_rdata = ep_mode_ff;
         `OFF_HUB_IRQ_EN: nxt_rdata = {7'h00, irq_en_ff};
         default: nxt_rdata = 8'h00; // unmapped reads zero
      endcase
   end

   // read data registered in setup phase, stable in access
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         o_prdata <= {24'h000000, nxt_rdata};
      end
   end
endmodule // hub_ctrl

/* File: verification/hub_ctrl_props.sv */
/* port checker for hub_ctrl; assumes one clock and the async low reset */
module hub_ctrl_props (
   input wire logic i_sys_clk, // clock
   input wire logic i_rst_n, // reset low
   input wire logic i_bus_reset, // bus reset
   input wire logic i_frame_end1, // frame point 1
   input wire logic i_frame_end2, // frame point 2
   input wire logic i_remote_wake, // wakeup
   input wire logic [3:0] i_ds_nonidle, // port traffic
   input wire logic i_tok_valid, // token pulse
   input wire hub_ctrl_pkg::token_t i_tok, // token
   input wire logic [3:0] o_port_fwd, // forwarding
   input wire logic o_eop_gen, // eop pulse
   input wire logic o_up_resume, // resume up
   input wire logic o_manual_force, // forcing
   input wire hub_ctrl_pkg::up_drive_t o_up_drive, // drive
   input wire hub_ctrl_pkg::ep_answer_t o_ep_answer, // answer
   input wire logic [31:0] o_prdata // read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] bab_ff; // ports babbling at frame point 2
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // hold the babbling ports seen at the last frame point 2
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bab_ff <= 4'h0;
      end else begin
         bab_ff <= i_frame_end2 ? (i_ds_nonidle & o_port_fwd) : bab_ff;
      end
   end
   eop_at_frame_a: assert property (i_frame_end1 |=> o_eop_gen)
      else $error("eop missing after frame point");
   eop_cause_a: assert property (o_eop_gen |-> $past(i_frame_end1))
      else $error("eop without frame point");
   babble_off_a: assert property ((i_frame_end2 &&
      (i_ds_nonidle & o_port_fwd) != 4'h0) |->
      ##2 (o_port_fwd & bab_ff) == 4'h0)
      else $error("babbling port still forwarding");
   bus_rst_a: assert property (i_bus_reset |-> ##2 o_port_fwd == 4'h0)
      else $error("bus reset left port forwarding");
   wake_up_a: assert property (i_remote_wake |=> o_up_resume)
      else $error("remote wakeup not sent upstream");
   no_force_a: assert property (!o_manual_force |->
      !o_up_drive.dp_oe && !o_up_drive.dm_oe)
      else $error("pins driven while engine in control");
   setup_nak_a: assert property ((i_tok_valid &&
      i_tok == hub_ctrl_pkg::TOK_SETUP &&
      o_ep_answer == hub_ctrl_pkg::ANS_ACK && !i_bus_reset) |=>
      (i_tok == hub_ctrl_pkg::TOK_SETUP ?
      o_ep_answer == hub_ctrl_pkg::ANS_ACK :
      o_ep_answer == hub_ctrl_pkg::ANS_NAK))
      else $error("setup did not force nak mode");
   rd_hi_zero_a: assert property (o_prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   // main scenarios reached
   cover property (i_frame_end2 && (i_ds_nonidle & o_port_fwd) != 4'h0);
   cover property (o_up_resume);
   cover property (o_manual_force);
endmodule // hub_ctrl_props
bind hub_ctrl hub_ctrl_props u_props (.i_sys_clk, .i_rst_n, .i_bus_reset,
   .i_frame_end1, .i_frame_end2, .i_remote_wake, .i_ds_nonidle, .i_tok_valid,
   .i_tok, .o_port_fwd, .o_eop_gen, .o_up_resume, .o_manual_force,
   .o_up_drive, .o_ep_answer, .o_prdata);

/* File: verification/usb_far_side.sv */
/* upstream line and frame point model; assumes bench drives line levels */
module usb_far_side (
   input wire logic i_sys_clk, // clock
   input wire logic i_rst_n, // reset low
   input wire logic i_frame_go, // start of frame end
   input wire logic [1:0] i_line, // d+ d- levels
   output logic o_frame_end1, // frame point 1 pulse
   output logic o_frame_end2, // frame point 2 pulse
   output logic o_up_dp, // upstream d+
   output logic o_up_dm, // upstream d-
   output logic o_up_nonidle // non idle pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_ff; // cycles to frame point 2
   logic [1:0] line_ff; // previous line state
   assign o_up_dp = i_line[1];
   assign o_up_dm = i_line[0];
   // frame point 2 follows point 1 by four cycles
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_frame_end1 <= 1'b0;
         o_frame_end2 <= 1'b0;
         cnt_ff <= 3'h0;
      end else begin
         o_frame_end1 <= i_frame_go;
         o_frame_end2 <= (cnt_ff == 3'h1);
         cnt_ff <= i_frame_go ? 3'h4 : cnt_ff - {2'h0, cnt_ff != 3'h0};
      end
   end
   // leaving idle j counts as upstream activity
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         line_ff <= 2'h0;
         o_up_nonidle <= 1'b0;
      end else begin
         line_ff <= i_line;
         o_up_nonidle <= (line_ff == 2'h2) && (i_line != 2'h2);
      end
   end
endmodule // usb_far_side

/* File: verification/tb_top.sv */
/* self-checking bench for hub_ctrl; assumes apb ready may take any time */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, bus_rst = 1'b0, psel = 1'b0;
   logic penable = 1'b0, pwrite = 1'b0, pkt = 1'b0, hsus = 1'b0;
   logic wake = 1'b0, tokv = 1'b0, ackd = 1'b0, go = 1'b0, conn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] cchg = 4'h0, disc = 4'h0, nidl = 4'h0, dres = 4'h0;
   logic [3:0] se0 = 4'h0, dp = 4'h0, dm = 4'h0, fwd, rdrv;
   logic [1:0] line = 2'h0;
   logic pready, pslverr, upres, irq, eop, frc, fe1, fe2, udp, udm, unid;
   hub_ctrl_pkg::token_t tok = hub_ctrl_pkg::TOK_IN;
   hub_ctrl_pkg::up_drive_t drv;
   hub_ctrl_pkg::ep_answer_t ans;
   int err_count = 0, checks = 0, cyc = 0;
   localparam logic [11:0] EPX [16] = '{12'h000, 12'h122, 12'h136, 12'h133,
      12'h100, 12'h001, 12'h153, 12'h040, 12'h002, 12'h001, 12'h152, 12'h151,
      12'h020, 12'h040, 12'h126, 12'h146};
   localparam logic [3:0] FEXP [8] = '{4'h0, 4'hD, 4'h7, 4'h5, 4'h5, 4'h1,
      4'h4, 4'h0};
   always #4 clk = ~clk;
   hub_ctrl dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_bus_reset(bus_rst),
      .i_paddr(paddr), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_pkt_active(pkt), .i_hub_suspended(hsus),
      .i_conn_change(cchg), .i_disconnect(disc), .i_ds_nonidle(nidl),
      .i_up_conn_open(conn), .i_ds_resume(dres), .i_remote_wake(wake),
      .i_ds_se0_out(se0), .i_ds_dp(dp), .i_ds_dm(dm), .i_frame_end1(fe1),
      .i_frame_end2(fe2), .i_up_nonidle(unid), .i_up_dp(udp), .i_up_dm(udm),
      .i_tok_valid(tokv), .i_tok(tok), .i_ack_done(ackd), .o_port_fwd(fwd),
      .o_port_resume_drive(rdrv), .o_up_resume(upres), .o_hub_irq(irq),
      .o_eop_gen(eop), .o_manual_force(frc), .o_up_drive(drv),
      .o_ep_answer(ans));
   usb_far_side u_far (.i_sys_clk(clk), .i_rst_n(rst_n), .i_frame_go(go),
      .i_line(line), .o_frame_end1(fe1), .o_frame_end2(fe2), .o_up_dp(udp),
      .o_up_dm(udm), .o_up_nonidle(unid));
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   task automatic t_reset;
      rd("stat", 8'h1F, 32'h0);
      rd("susp", 8'h4D, 32'h0);
      rd("res", 8'h4E, 32'h0);
      rd("en", 8'h49, 32'h0);
      rd("mode", 8'h12, 32'h0);
      rd("unmapped", 8'h7C, 32'h0);
      chk("slverr", pslverr, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_enable;
      pkt <= 1'b1;
      wr(8'h49, 32'h0F);
      repeat (3) @(posedge clk);
      chk("fwd busy", fwd, 32'h0);
      pkt <= 1'b0;
      repeat (3) @(posedge clk);
      chk("fwd idle", fwd, 32'hF);
      wr(8'h60, 32'h01);
      nidl <= 4'h2;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (8) @(posedge clk);
      nidl <= 4'h0;
      chk("fwd babble", fwd, 32'hD);
      rd("en", 8'h49, 32'h0D);
      $display("t_enable done");
   endtask
   task automatic t_status;
      se0 <= 4'h5;
      dp <= 4'hB;
      dm <= 4'h5;
      line <= 2'h2;
      repeat (2) @(posedge clk);
      line <= 2'h1;
      rd("se0", 8'h4F, 32'h05);
      rd("diff", 8'h50, 32'h0A);
      rd("stat k", 8'h1F, 32'h18);
      wr(8'h1F, 32'h08);
      rd("stat keep", 8'h1F, 32'h18);
      wr(8'h1F, 32'h00);
      line <= 2'h2;
      rd("stat j", 8'h1F, 32'h20);
      for (int c = 0; c < 8; c++) begin
         wr(8'h1F, c);
         chk("force", frc, c != 0);
         chk("drive", {drv.dp_out & drv.dp_oe, drv.dp_oe,
            drv.dm_out & drv.dm_oe, drv.dm_oe}, FEXP[c]);
      end
      wr(8'h1F, 32'h00);
      $display("t_status done");
   endtask
   task automatic t_suspend;
      wr(8'h4D, 32'h81);
      @(posedge clk);
      chk("fwd susp", fwd, 32'hC);
      dres <= 4'h1;
      @(posedge clk);
      dres <= 4'h0;
      #1 chk("reflect", rdrv, 32'h1);
      chk("irq res", irq, 32'h1);
      @(posedge clk);
      rd("res", 8'h4E, 32'h01);
      dres <= 4'h4;
      @(posedge clk);
      dres <= 4'h0;
      #1 chk("no reflect", rdrv, 32'h0);
      @(posedge clk);
      cchg <= 4'h8;
      @(posedge clk);
      cchg <= 4'h0;
      #1 chk("wake on", upres, 32'h1);
      @(posedge clk);
      disc <= 4'h1;
      @(posedge clk);
      disc <= 4'h0;
      rd("susp disc", 8'h4D, 32'h80);
      wr(8'h4D, 32'h00);
      cchg <= 4'h8;
      @(posedge clk);
      cchg <= 4'h0;
      #1 chk("wake off", upres, 32'h0);
      @(posedge clk);
      wake <= 1'b1;
      hsus <= 1'b1;
      cchg <= 4'h2;
      @(posedge clk);
      {wake, hsus, cchg} <= 6'h00;
      #1 chk("remote", upres, 32'h1);
      chk("irq susp", irq, 32'h1);
      @(posedge clk);
      bus_rst <= 1'b1;
      @(posedge clk);
      bus_rst <= 1'b0;
      rd("en brst", 8'h49, 32'h0);
      rd("res brst", 8'h4E, 32'h0);
      // open upstream path at frame point 2 babbles every port
      wr(8'h49, 32'h0F);
      conn <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (8) @(posedge clk);
      conn <= 1'b0;
      chk("fwd conn", fwd, 32'h0);
      $display("t_suspend done");
   endtask
   task automatic t_endpoint;
      for (int m = 0; m < 16; m++) begin
         wr(8'h12, m);
         for (int t = 0; t < 3; t++) begin
            tok <= hub_ctrl_pkg::token_t'(t);
            @(posedge clk);
            #1 if (EPX[m][8-4*t +: 4] != 4'hF)
               chk("answer", ans, EPX[m][8-4*t +: 4]);
            @(posedge clk);
         end
      end
      for (int i = 0; i < 4; i++) begin
         wr(8'h12, 32'h89 + 2 * i);
         tok <= (i == 0) ? hub_ctrl_pkg::TOK_OUT : hub_ctrl_pkg::TOK_IN;
         @(posedge clk);
         #1 if (i % 2 == 0) chk("stall", ans, 32'h3);
         @(posedge clk);
         wr(8'h12, 32'h9 + 2 * i);
         ackd <= 1'b1;
         @(posedge clk);
         ackd <= 1'b0;
         rd("ack move", 8'h12, 32'h8 + 2 * i);
      end
      for (int m = 3; m >= 0; m -= 3) begin
         wr(8'h12, m);
         tok <= hub_ctrl_pkg::TOK_SETUP;
         tokv <= 1'b1;
         @(posedge clk);
         tokv <= 1'b0;
         tok <= hub_ctrl_pkg::TOK_IN;
         rd("setup", 8'h12, m == 3);
      end
      $display("t_endpoint done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_enable();
      t_status();
      t_suspend();
      t_endpoint();
      end_of_test();
   end
endmodule // tb_top
